// ### icr_params.svh
/*
 Offsets, field positions, reset values and timing counts of the input control block.
 Assumes a 50 MHz pclk; the debounce oscillator runs from pclk through a divider enable.
*/
// Behaviour
// - Bit 7 sets the interrupt pin polarity: clear drives it active low, set drives it active high.
// - Bit 6 enables a debounce that needs the external interrupt input stable for 1,024 oscillator clocks.
// - Bits 5-4 choose the trigger: 00b low level, 01b falling edge, 10b high level, 11b rising edge.
// - Bit 2 selects text mode when set, and it reads 0 while the canvas uses linear addressing.
// - Destination 00b sends data port accesses to display RAM, with read-modify-write allowed.
// - Destination 01b sends accesses to a 256-byte gamma table chosen by the host, written in one run.
// - Destination 10b sends accesses to cursor RAM, keeps only the low data byte and refuses reads.
// - Cursor RAM holds 4 sets of 128x16 bits; the host picks a set and writes 256 bytes in one run.
// - Destination 11b sends writes to a write-only 64x12 palette, keeping 4 bits of even bytes.
// - The data port routes each host write, and each read for destinations 00b and 01b, to the memory picked by bits 1-0.
`ifndef ICR_PARAMS_SVH
`define ICR_PARAMS_SVH

// Register byte addresses
`define ICR_OFF_CTRL 12'h00C
`define ICR_OFF_DATA 12'h010
`define ICR_OFF_STAT 12'h020
`define ICR_OFF_MASK 12'h024
`define ICR_OFF_STATE 12'h028

// Control field positions
`define ICR_BIT_POL 7
`define ICR_BIT_DEB 6
`define ICR_TRIG_HI 5
`define ICR_TRIG_LO 4
`define ICR_BIT_TEXT 2
`define ICR_DEST_HI 1
`define ICR_DEST_LO 0
`define ICR_CTRL_RESET 8'h00
`define ICR_CTRL_WMASK 8'hFF

// Interrupt status bits
`define ICR_EV_EXT 0
`define ICR_EV_RDERR 1
`define ICR_EV_BULK 2
`define ICR_EV_NUM 3

// Debounce timing
`define ICR_CLK_MHZ 50
`define ICR_OSC_MHZ 10
`define ICR_OSC_DIV (`ICR_CLK_MHZ / `ICR_OSC_MHZ)
`define ICR_DEB_OSC 1024

// Bulk lengths in bytes
`define ICR_GAMMA_BYTES 256
`define ICR_CURSOR_BYTES 256
`define ICR_PAL_BYTES 128

`endif

// ### icr_pkg.sv
/*
 Types shared by the input control block.
 Assumes icr_params.svh is compiled alongside.
*/
package icr_pkg;
	typedef enum logic [1:0] {
		ICR_TRIG_LOW,
		ICR_TRIG_FALL,
		ICR_TRIG_HIGH,
		ICR_TRIG_RISE
	} icr_trig_type;

	typedef enum logic [1:0] {
		ICR_DST_DRAM,
		ICR_DST_GAMMA,
		ICR_DST_CURSOR,
		ICR_DST_PAL
	} icr_dst_type;

	// Control register layout
	typedef struct packed {
		logic pol_high;
		logic deb_en;
		icr_trig_type trig;
		logic spare;
		logic text_mode;
		icr_dst_type dest;
	} icr_ctrl_type;

	// One memory port access towards the selected memory
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} icr_mem_type;
endpackage

// ### icr_debounce.sv
/*
 Debouncer for the external interrupt input.
 Assumes the input is synchronous to pclk and osc_en pulses once per oscillator clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "icr_params.svh"

module icr_debounce #(
	parameter int STABLE = `ICR_DEB_OSC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic osc_en,
	input wire logic enable,
	input wire logic din,
	output logic dout
);
	logic [$clog2(STABLE+1)-1:0] cnt_q, cnt_d;
	logic state_q, state_d;
	logic last_q, last_d;

	// Output follows only after the input has held for STABLE oscillator clocks
	always_comb begin
		cnt_d = cnt_q;
		state_d = state_q;
		last_d = din;
		if (!enable) begin
			state_d = din; // Bypass keeps the stable copy current
			cnt_d = '0;
		end else if (din != last_q) begin
			cnt_d = '0; // Any change restarts the window
		end else if (osc_en) begin
			if (cnt_q == ($clog2(STABLE+1))'(STABLE - 1)) begin
				state_d = din;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			state_q <= 1'b1;
			last_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			state_q <= state_d;
			last_q <= last_d;
		end
	end

	assign dout = state_q;
endmodule
`default_nettype wire

// ### icr_input_control.sv
/*
 Input control register with its interrupt input logic and data port routing.
 Assumes an APB master on pclk; downstream memories answer reads in the same cycle that mem_rd is out.
*/
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "icr_params.svh"

module icr_input_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic external_interrupt_input,
	input wire logic canvas_linear,
	input wire logic [7:0] mem_rdata,
	output logic int_pin,
	output logic irq,
	output logic text_mode,
	output icr_pkg::icr_dst_type mem_dest,
	output icr_pkg::icr_mem_type dram_acc,
	output icr_pkg::icr_mem_type gamma_acc,
	output icr_pkg::icr_mem_type cursor_acc,
	output icr_pkg::icr_mem_type pal_acc
);
	import icr_pkg::*;

	localparam int NEV = `ICR_EV_NUM;

	icr_ctrl_type ctrl_q, ctrl_d;
	logic [NEV-1:0] stat_q, stat_d, mask_q, mask_d;
	logic [7:0] bulk_q, bulk_d;
	logic int_pin_q, int_pin_d, irq_q, irq_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic text_q, text_d;
	icr_dst_type dest_q, dest_d;
	icr_mem_type acc_q [4];
	icr_mem_type acc_d [4];
	logic [$clog2(`ICR_OSC_DIV)-1:0] div_q, div_d;
	logic osc_en, ext_clean, ext_prev_q, trig_hit;
	logic [NEV-1:0] ev;
	logic access, wr_en, rd_en, data_rd_wait_q, data_rd_wait_d;
	logic [7:0] ctrl_rd;
	logic [8:0] bulk_len;

	// Oscillator clock enable from pclk; one cycle per oscillator period
	always_comb begin
		div_d = div_q + 1'b1;
		osc_en = (div_q == ($clog2(`ICR_OSC_DIV))'(`ICR_OSC_DIV - 1));
		if (osc_en) begin
			div_d = '0;
		end
	end

	icr_debounce #(
		.STABLE(`ICR_DEB_OSC)
	) u_deb (
		.pclk(pclk),
		.presetn(presetn),
		.osc_en(osc_en),
		.enable(ctrl_q.deb_en),
		.din(external_interrupt_input),
		.dout(ext_clean)
	);

	// Trigger decode; level types fire every cycle the level holds
	always_comb begin
		case (ctrl_q.trig)
			ICR_TRIG_LOW: trig_hit = !ext_clean;
			ICR_TRIG_FALL: trig_hit = ext_prev_q && !ext_clean;
			ICR_TRIG_HIGH: trig_hit = ext_clean;
			ICR_TRIG_RISE: trig_hit = !ext_prev_q && ext_clean;
			default: trig_hit = 1'b0;
		endcase
	end

	// APB decode; every access completes in its second access cycle except display RAM and gamma data port reads, which complete in their third
	assign access = psel && penable && !pready_q;
	assign wr_en = access && pwrite;
	assign rd_en = access && !pwrite;
	assign ctrl_rd = {ctrl_q[7:3], ctrl_q.text_mode && !canvas_linear, ctrl_q[1:0]};

	// Bulk run length follows the destination
	always_comb begin
		case (ctrl_q.dest)
			ICR_DST_GAMMA: bulk_len = 9'(`ICR_GAMMA_BYTES);
			ICR_DST_CURSOR: bulk_len = 9'(`ICR_CURSOR_BYTES);
			ICR_DST_PAL: bulk_len = 9'(`ICR_PAL_BYTES);
			default: bulk_len = 9'h000;
		endcase
	end

	// Register, routing and interrupt next state
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		bulk_d = bulk_q;
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		data_rd_wait_d = 1'b0;
		for (int i = 0; i < 4; i++) begin
			acc_d[i] = '0;
		end
		ev = '0;
		ev[`ICR_EV_EXT] = trig_hit;
		if (wr_en) begin
			pready_d = 1'b1;
			case (paddr)
				`ICR_OFF_CTRL: ctrl_d = icr_ctrl_type'(pwdata[7:0] & `ICR_CTRL_WMASK);
				`ICR_OFF_MASK: mask_d = pwdata[NEV-1:0];
				`ICR_OFF_STAT: ;
				`ICR_OFF_DATA: begin
					acc_d[ctrl_q.dest].wr = 1'b1;
					acc_d[ctrl_q.dest].wdata = pwdata[7:0];
					if (ctrl_q.dest == ICR_DST_PAL && !bulk_q[0]) begin
						acc_d[ctrl_q.dest].wdata = {4'h0, pwdata[3:0]};
					end
					if (ctrl_q.dest != ICR_DST_DRAM) begin
						bulk_d = bulk_q + 1'b1;
						if ({1'b0, bulk_q} == bulk_len - 9'h001) begin
							bulk_d = 8'h00;
							ev[`ICR_EV_BULK] = 1'b1; // Full table written
						end
					end
				end
				default: pslverr_d = 1'b1;
			endcase
		end else if (rd_en && !data_rd_wait_q) begin
			pready_d = 1'b1;
			prdata_d = 32'h0000_0000;
			case (paddr)
				`ICR_OFF_CTRL: prdata_d[7:0] = ctrl_rd;
				`ICR_OFF_STAT: prdata_d[NEV-1:0] = stat_q;
				`ICR_OFF_MASK: prdata_d[NEV-1:0] = mask_q;
				`ICR_OFF_STATE: prdata_d[7:0] = bulk_q;
				`ICR_OFF_DATA: begin
					if (ctrl_q.dest == ICR_DST_DRAM || ctrl_q.dest == ICR_DST_GAMMA) begin
						acc_d[ctrl_q.dest].rd = 1'b1;
						pready_d = 1'b0;
						data_rd_wait_d = 1'b1;
					end else begin
						pslverr_d = 1'b1; // Cursor and palette refuse reads
						ev[`ICR_EV_RDERR] = 1'b1;
					end
				end
				default: pslverr_d = 1'b1;
			endcase
		end else if (data_rd_wait_q) begin
			pready_d = 1'b1; // Memory data is taken in the cycle that the registered read strobe is out
			prdata_d = {24'h000000, mem_rdata};
		end
		if (wr_en && paddr == `ICR_OFF_CTRL && pwdata[1:0] != ctrl_q.dest) begin
			bulk_d = 8'h00; // New destination restarts the run
		end
		// Set wins over write-one-to-clear
		stat_d = stat_q;
		if (wr_en && paddr == `ICR_OFF_STAT) begin
			stat_d = stat_q & ~pwdata[NEV-1:0];
		end
		stat_d = stat_d | ev;
		irq_d = |(stat_d & mask_d);
		int_pin_d = ctrl_d.pol_high ? irq_d : !irq_d;
		text_d = ctrl_d.text_mode && !canvas_linear;
		dest_d = ctrl_d.dest;
	end

	// All state registered; reset clears every control bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= icr_ctrl_type'(`ICR_CTRL_RESET);
			mask_q <= '0;
			stat_q <= '0;
			bulk_q <= 8'h00;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			data_rd_wait_q <= 1'b0;
			irq_q <= 1'b0;
			int_pin_q <= 1'b1;
			text_q <= 1'b0;
			dest_q <= ICR_DST_DRAM;
			div_q <= '0;
			ext_prev_q <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				acc_q[i] <= '0;
			end
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			bulk_q <= bulk_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			data_rd_wait_q <= data_rd_wait_d;
			irq_q <= irq_d;
			int_pin_q <= int_pin_d;
			text_q <= text_d;
			dest_q <= dest_d;
			div_q <= div_d;
			ext_prev_q <= ext_clean;
			for (int i = 0; i < 4; i++) begin
				acc_q[i] <= acc_d[i];
			end
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;
	assign irq = irq_q;
	assign int_pin = int_pin_q;
	assign text_mode = text_q;
	assign mem_dest = dest_q;
	assign dram_acc = acc_q[0];
	assign gamma_acc = acc_q[1];
	assign cursor_acc = acc_q[2];
	assign pal_acc = acc_q[3];
endmodule
`default_nettype wire

// ### icr_mem_model.sv
/* Memory model feeding mem_rdata for data port reads.
 Assumes the strobes are pclk pulses; data holds two cycles after a strobe. */
`timescale 1ns/1ps
`default_nettype none
module icr_mem_model (
	input wire logic pclk,
	input wire icr_pkg::icr_mem_type dram_acc,
	input wire icr_pkg::icr_mem_type gamma_acc,
	output logic [7:0] mem_rdata
);
	import icr_pkg::*;
	logic [7:0] v;
	logic [7:0] h = 8'h00;
	logic p = 1'b0;
	logic rd;
	// Fixed byte per memory so a wrong route shows up
	assign rd = dram_acc.rd | gamma_acc.rd;
	assign v = dram_acc.rd ? 8'h3C : 8'h5A;
	assign mem_rdata = rd ? v : (p ? h : ~h);
	// Invert when idle, so stale data alternates between the last byte and its complement
	always @(posedge pclk) begin
		p <= rd;
		h <= rd ? v : ~h;
	end
endmodule
`default_nettype wire

// ### icr_input_control_assertions.sv
/* Port checker for the input control block.
 Assumes one pclk domain and an active low presetn. */
`timescale 1ns/1ps
`default_nettype none
module icr_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic canvas_linear,
	input wire logic text_mode,
	input wire icr_pkg::icr_dst_type mem_dest,
	input wire icr_pkg::icr_mem_type dram_acc,
	input wire icr_pkg::icr_mem_type gamma_acc,
	input wire icr_pkg::icr_mem_type cursor_acc,
	input wire icr_pkg::icr_mem_type pal_acc
);
	import icr_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup then access phase of one request
	sequence s_req;
		psel && !penable ##1 psel && penable;
	endsequence
	a_apb_answer: assert property (s_req |-> ##[1:2] pready)
		else $error("no answer in time");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_text_forced: assert property (canvas_linear |=> !text_mode)
		else $error("text mode with linear canvas");
	a_no_crd: assert property (!cursor_acc.rd)
		else $error("cursor read issued");
	a_no_prd: assert property (!pal_acc.rd)
		else $error("palette read issued");
	a_dram_route: assert property (dram_acc.wr || dram_acc.rd |-> mem_dest == ICR_DST_DRAM)
		else $error("display access off route");
	a_gamma_route: assert property (gamma_acc.wr |-> mem_dest == ICR_DST_GAMMA)
		else $error("gamma access off route");
	a_cursor_route: assert property (cursor_acc.wr |-> mem_dest == ICR_DST_CURSOR)
		else $error("cursor access off route");
	a_pal_route: assert property (pal_acc.wr |-> mem_dest == ICR_DST_PAL)
		else $error("palette access off route");
endmodule
bind icr_input_control icr_checker u_chk (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .canvas_linear, .text_mode, .mem_dest, .dram_acc, .gamma_acc,
	.cursor_acc, .pal_acc);
`default_nettype wire

// ### testbench.sv
/* Self-checking bench for the input control block.
 Assumes icr_params.svh offsets; the APB slave may insert wait states. */
`timescale 1ns/1ps
`default_nettype none
`include "icr_params.svh"
`define CHK(n,e,g) chk(n, 32'(e), 32'(g));
module testbench;
	import icr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic pready, pslverr, rerr, int_pin, irq, text_mode;
	logic ext = 1, canvas_linear = 0;
	logic [7:0] mem_rdata, hw = 0;
	logic [1:0] hd = 2'h3;
	icr_dst_type mem_dest;
	icr_mem_type dram_acc, gamma_acc, cursor_acc, pal_acc;
	int num_errors = 0, cmp_count = 0, cyc = 0, k;
	icr_input_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .external_interrupt_input(ext), .canvas_linear,
		.mem_rdata, .int_pin, .irq, .text_mode, .mem_dest, .dram_acc, .gamma_acc,
		.cursor_acc, .pal_acc);
	icr_mem_model u_mem (.pclk, .dram_acc, .gamma_acc, .mem_rdata);
	always #10 pclk = ~pclk;
	// Note which memory took the last write, and its byte
	// Sampled mid-cycle so the note is settled by the edge at which a task returns
	always @(negedge pclk) begin
		if (dram_acc.wr) {hd, hw} <= {2'h0, dram_acc.wdata};
		if (gamma_acc.wr) {hd, hw} <= {2'h1, gamma_acc.wdata};
		if (cursor_acc.wr) {hd, hw} <= {2'h2, cursor_acc.wdata};
		if (pal_acc.wr) {hd, hw} <= {2'h3, pal_acc.wdata};
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// One APB transfer; waits on pready, the timeout cuts a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Cycle ceiling well above the expected run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		`CHK("int_pin", 1'b1, int_pin)
		apb(0, `ICR_OFF_CTRL, 0);
		`CHK("ctrl", 32'h0, rdat)
		apb(0, 12'h100, 0);
		`CHK("unmapped", 1'b1, rerr)
		$display("test reset done");
		apb(1, `ICR_OFF_CTRL, 32'h84); // Core idle here
		apb(0, `ICR_OFF_CTRL, 0);
		`CHK("ctrl", 32'h84, rdat)
		`CHK("text", 1'b1, text_mode)
		`CHK("int_pin", 1'b0, int_pin)
		canvas_linear <= 1;
		apb(0, `ICR_OFF_CTRL, 0);
		`CHK("ctrl", 32'h80, rdat)
		`CHK("text", 1'b0, text_mode)
		canvas_linear <= 0;
		$display("test mode done");
		// Each destination: write, dummy read, real read
		for (int i = 0; i < 4; i++) begin
			apb(1, `ICR_OFF_CTRL, i);
			apb(1, `ICR_OFF_DATA, 32'h1A5);
			`CHK("dest", i, hd)
			`CHK("mdest", i, mem_dest)
			`CHK("wbyte", i == 3 ? 8'h05 : 8'hA5, hw)
			apb(0, `ICR_OFF_DATA, 0);
			apb(0, `ICR_OFF_DATA, 0);
			`CHK("rderr", i > 1, rerr)
			if (i < 2) `CHK("rdata", i ? 32'h5A : 32'h3C, rdat)
		end
		apb(1, `ICR_OFF_CTRL, 0);
		apb(1, `ICR_OFF_CTRL, 3);
		repeat (128) apb(1, `ICR_OFF_DATA, 32'hFF);
		`CHK("odd", 8'hFF, hw)
		apb(0, `ICR_OFF_STAT, 0);
		`CHK("bulk", 2'h3, rdat[2:1])
		apb(1, `ICR_OFF_STAT, 32'h7);
		// Full gamma and cursor runs; the done flag must rise on the last byte only
		for (int d = 1; d < 3; d++) begin
			apb(1, `ICR_OFF_CTRL, d);
			apb(1, `ICR_OFF_STAT, 32'h7);
			repeat (255) apb(1, `ICR_OFF_DATA, d);
			apb(0, `ICR_OFF_STATE, 0);
			`CHK("count", 8'hFF, rdat)
			apb(0, `ICR_OFF_STAT, 0);
			`CHK("early_done", 1'b0, rdat[2])
			apb(1, `ICR_OFF_DATA, d);
			apb(0, `ICR_OFF_STAT, 0);
			`CHK("done", 1'b1, rdat[2])
			apb(0, `ICR_OFF_STATE, 0);
			`CHK("wrap", 8'h00, rdat)
		end
		$display("test route done");
		// Each trigger type; rising case also flips the pin polarity
		apb(1, `ICR_OFF_MASK, 32'h1);
		apb(0, `ICR_OFF_MASK, 0);
		`CHK("mask", 32'h1, rdat)
		for (int t = 0; t < 4; t++) begin
			ext <= ~t[1];
			apb(1, `ICR_OFF_CTRL, t * 16 + (t / 3) * 128);
			apb(1, `ICR_OFF_STAT, 32'h1);
			repeat (2) @(posedge pclk);
			`CHK("quiet", 1'b0, irq)
			ext <= t[1];
			for (k = 0; k < 20 && irq !== 1'b1; k++) @(posedge pclk);
			`CHK("trig", 1'b1, irq)
			`CHK("pin", t == 3, int_pin)
			ext <= ~t[1];
			repeat (4) @(posedge pclk);
			apb(1, `ICR_OFF_STAT, 32'h1);
			repeat (2) @(posedge pclk);
			`CHK("clear", 1'b0, irq)
		end
		$display("test trigger done");
		apb(1, `ICR_OFF_CTRL, 32'h60);
		apb(1, `ICR_OFF_STAT, 32'h1);
		ext <= 1;
		repeat (4000) @(posedge pclk);
		`CHK("early", 1'b0, irq)
		for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge pclk);
		`CHK("late", 1'b1, irq)
		apb(1, `ICR_OFF_MASK, 0);
		repeat (2) @(posedge pclk);
		`CHK("masked", 1'b0, irq)
		$display("test debounce done");
		// Reset in mid-run must bring every control bit back to zero
		apb(1, `ICR_OFF_CTRL, 32'h87); // Core idle here
		`CHK("pre_pin", 1'b0, int_pin)
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		`CHK("rst_pin", 1'b1, int_pin)
		`CHK("rst_text", 1'b0, text_mode)
		`CHK("rst_dest", 2'h0, mem_dest)
		apb(0, `ICR_OFF_CTRL, 0);
		`CHK("rst_ctrl", 32'h0, rdat)
		$display("test reset again done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
